// *** include/lvdc_pkg.sv ***
// Package for the low-voltage detector control block
package lvdc_pkg;
  // APB byte addresses (printed offsets are multiples of four? 0xFF51 is not: indices kept)
  localparam logic [15:0] LVDC_IDX_CONTROL = 16'hFF50;
  localparam logic [15:0] LVDC_IDX_LEVEL = 16'hFF51;
  localparam logic [17:0] LVDC_ADDR_CONTROL = {LVDC_IDX_CONTROL, 2'b00};
  localparam logic [17:0] LVDC_ADDR_LEVEL = {LVDC_IDX_LEVEL, 2'b00};
  localparam int LVDC_ADDR_W = 18;
  // Control register fields
  localparam int LVDC_BIT_ENABLE = 7;
  localparam int LVDC_BIT_RESET_MODE = 1;
  localparam int LVDC_BIT_FLAG = 0;
  localparam logic [7:0] LVDC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] LVDC_LEVEL_RESET = 8'h00;
  localparam logic [3:0] LVDC_LEVEL_MAX = 4'h9;
  localparam logic [31:0] LVDC_RDATA_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic enable;
    logic reset_mode;
  } lvdc_ctrl_type;
endpackage : lvdc_pkg

// *** rtl/lvdc_ctrl.sv ***
// Low-voltage detector control: registers, synchroniser, interrupt and reset requests
// Function
// R1: Level-select register clears to zero on every reset.
// R2: Software writes level-select only as whole bytes.
// R3: Low four level bits select ten thresholds; codes ten to fifteen forbidden.
// R4: Software writes zero to upper four level bits.
// R5: Reset mode asserts internal reset while supply below threshold.
// R6: Interrupt mode raises interrupt while supply below threshold.
// R7: Control bits: enable bit 7, reset mode bit 1, flag bit 0.
// R8: Software waits 0.2 ms after enable before trusting flag.
// R9: Reset-mode start sequence: mask, level, enable, wait, poll, set mode.
// R10: Unmasked interrupt may fire right after enable is set.
// R11: Setting reset mode with supply above threshold gives no reset.
// R12: Stop reset mode by writing zero, or clear mode then enable.
// R13: Interrupt-mode start: first five steps, clear pending, unmask, enable.
// R14: Stop interrupt mode by writing zero or clearing enable.
// R15: Service routine confirms supply, clears pending flag, re-enables interrupts.
// R16: After detector reset software waits out supply fluctuation.
// R17: Detector reset sets the reset-cause flag, bit 0 of cause register.
// R18: Flag drives interrupt only with enable one and reset mode zero.
// R19: Enable and mode cleared by every reset except detector reset.
// R20: Flag reads zero when disabled, else reflects comparison.
// R21: Comparator output passes two-stage synchroniser before use.
`timescale 1ns/1ps
`default_nettype none
module lvdc_ctrl
  import lvdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // High when the analog comparator sees supply below threshold
  input wire logic supply_below_async,
  // Set when the current reset came from this detector
  input wire logic low_supply_reset_cause,
  output logic [3:0] level_code,
  output logic comparator_enable,
  output logic low_supply_irq,
  output logic low_supply_reset_req
);

  lvdc_ctrl_type ctrl_q;
  logic [7:0] level_q;
  logic sync1_q;
  logic sync2_q;
  logic below_threshold_flag;
  logic acc_wr;
  logic acc_rd;
  logic hit_control;
  logic hit_level;
  logic [31:0] rdata_q;

  assign hit_control = (paddr[LVDC_ADDR_W-1:0] == LVDC_ADDR_CONTROL) && (paddr[31:LVDC_ADDR_W] == '0);
  assign hit_level = (paddr[LVDC_ADDR_W-1:0] == LVDC_ADDR_LEVEL) && (paddr[31:LVDC_ADDR_W] == '0);
  assign acc_wr = psel && penable && pwrite && pstrb[0];
  assign acc_rd = psel && !penable && !pwrite;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_control || hit_level);
  assign prdata = rdata_q;

  // Only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= supply_below_async; // R21
      sync2_q <= sync1_q; // R21
    end
  end

  assign below_threshold_flag = ctrl_q.enable && sync2_q; // R20

  // Level register: always cleared, any reset source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= LVDC_LEVEL_RESET; // R1
    end else if (acc_wr && hit_level) begin
      // Upper nibble kept at zero; codes above nine are refused
      if (pwdata[3:0] <= LVDC_LEVEL_MAX) begin // R3
        level_q <= {4'h0, pwdata[3:0]}; // R4
      end
    end
  end

  // Control bits survive a detector-caused reset
  // Synchronous clear: an async clear could not spare them; needs pclk running in reset
  always_ff @(posedge pclk) begin
    if (!presetn) begin
      if (!low_supply_reset_cause) begin
        ctrl_q <= '0; // R19
      end
    end else if (acc_wr && hit_control) begin
      ctrl_q.enable <= pwdata[LVDC_BIT_ENABLE]; // R7
      ctrl_q.reset_mode <= pwdata[LVDC_BIT_RESET_MODE]; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= LVDC_RDATA_UNMAPPED;
    end else if (acc_rd) begin
      if (hit_control) begin
        rdata_q <= {24'h0, ctrl_q.enable, 5'h00, ctrl_q.reset_mode, below_threshold_flag}; // R7
      end else if (hit_level) begin
        rdata_q <= {24'h0, level_q};
      end else begin
        rdata_q <= LVDC_RDATA_UNMAPPED;
      end
    end
  end

  assign level_code = level_q[3:0];
  assign comparator_enable = ctrl_q.enable;
  // Request lines are levels that follow the synchronised flag
  assign low_supply_irq = below_threshold_flag && !ctrl_q.reset_mode; // R6 R10 R18
  assign low_supply_reset_req = below_threshold_flag && ctrl_q.reset_mode; // R5 R11 R17

endmodule : lvdc_ctrl
`default_nettype wire

// *** verif/lvdc_ctrl_properties.sv ***
// Port-level checker for the low-voltage detector control block
`timescale 1ns/1ps
`default_nettype none
module lvdc_ctrl_properties import lvdc_pkg::*; (input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [31:0] paddr, pwdata, prdata, input wire logic [3:0] pstrb, level_code, input wire logic pready,
  pslverr, supply_below_async, low_supply_reset_cause, comparator_enable, low_supply_irq, low_supply_reset_req);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr(a); psel && penable && pwrite && pstrb[0] && paddr == a; endsequence
  a_reset_clears: assert property (disable iff (1'b0) !presetn |-> level_code == 4'h0 ##1 ($past(low_supply_reset_cause) || !comparator_enable)) else $error("reset value");
  a_level_load: assert property (wr(32'(LVDC_ADDR_LEVEL)) ##0 pwdata[3:0] <= 4'h9 |=> level_code == $past(pwdata[3:0])) else $error("level load");
  a_level_refuse: assert property (wr(32'(LVDC_ADDR_LEVEL)) ##0 pwdata[3:0] > 4'h9 |=> $stable(level_code)) else $error("bad code");
  a_enable_load: assert property (wr(32'(LVDC_ADDR_CONTROL)) |=> comparator_enable == $past(pwdata[7])) else $error("enable");
  a_irq_gate: assert property (low_supply_irq |-> comparator_enable && !low_supply_reset_req) else $error("irq gate");
  a_req_gate: assert property (low_supply_reset_req |-> comparator_enable) else $error("req gate");
  a_sync_delay: assert property (low_supply_irq || low_supply_reset_req |-> $past(supply_below_async, 2)) else $error("sync");
  a_sync_fire: assert property (comparator_enable && $past(supply_below_async, 2) |-> low_supply_irq || low_supply_reset_req) else $error("no request");
  a_unmapped_err: assert property (psel && penable && paddr != 32'(LVDC_ADDR_LEVEL) && paddr != 32'(LVDC_ADDR_CONTROL) |-> pslverr) else $error("pslverr");
endmodule : lvdc_ctrl_properties
bind lvdc_ctrl lvdc_ctrl_properties u_props (.*);
`default_nettype wire

// *** verif/tb_lvdc_ctrl.sv ***
// Self-checking bench for the low-voltage detector control block
`timescale 1ns/1ps
`default_nettype none
module tb_lvdc_ctrl import lvdc_pkg::*; ;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, sb = 0, cause = 0, pready, pslverr, en, irq, rq;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [3:0] level_code, lv = 4'h0;
  logic [32:0] q[$];
  logic [15:0] lf = 16'hAB12;
  int miscompares = 0, n_compared = 0, cyc = 0;
  localparam logic [31:0] ca = 32'(LVDC_ADDR_CONTROL), la = 32'(LVDC_ADDR_LEVEL);
  always #12.5 pclk = ~pclk;
  lvdc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_below_async(sb),
    .low_supply_reset_cause(cause), .level_code(level_code), .comparator_enable(en), .low_supply_irq(irq),
    .low_supply_reset_req(rq));
  task automatic end_of_test;
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [32:0] g, x);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask : cmp
  // Read expectations queue up before the setup cycle so the monitor never runs dry
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] x);
    if (!w) q.push_back(x);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  always @(posedge pclk) if (psel && penable && !pwrite && pready) cmp({pslverr, prdata}, q.pop_front());
  always @(posedge pclk) if (++cyc > 3000) begin
    miscompares++;
    end_of_test();
  end
  initial begin
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, la, 0, 33'h0);
    apb(0, ca, 0, 33'h0);
    for (int k = 0; k < 16; k++) begin
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      // Random fill only in unused byte lanes; byte written whole
      apb(1, la, {lf, 8'h00, 4'h0, 4'(k)}, 0);
      if (k <= 9) lv = 4'(k);
      apb(0, la, 0, {29'h0, lv});
      cmp(33'(level_code), 33'(lv));
    end
    apb(1, ca, 32'h80, 0);
    repeat (4) @(posedge pclk);
    apb(0, ca, 0, 33'h80);
    // All-ones write: only enable and mode bits may stick
    apb(1, ca, 32'hFF, 0);
    apb(0, ca, 0, 33'h82);
    cmp({31'h0, irq, rq}, 33'h0);
    sb <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, ca, 0, 33'h83);
    cmp({30'h0, en, irq, rq}, 33'h5);
    apb(1, ca, 32'h80, 0);
    apb(0, ca, 0, 33'h81);
    cmp({30'h0, en, irq, rq}, 33'h6);
    sb <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(0, ca, 0, 33'h80);
    cmp({31'h0, irq, rq}, 33'h0);
    apb(1, ca, 32'h00, 0);
    apb(0, ca, 0, 33'h0);
    // Detector-caused reset keeps enable and mode
    apb(1, ca, 32'h82, 0);
    cause <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cause <= 1'b0;
    @(posedge pclk);
    apb(0, ca, 0, 33'h82);
    apb(1, ca, 32'h00, 0);
    apb(0, 32'h0, 0, {1'b1, 32'h0});
    apb(1, la, 32'h5, 0);
    presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    @(posedge pclk);
    apb(0, la, 0, 33'h0);
    apb(0, ca, 0, 33'h0);
    end_of_test();
  end
endmodule : tb_lvdc_ctrl
`default_nettype wire
